// file: mio_map.svh
/*
 Address, field and reset constants of the multi-I/O port decode logic.
 Assumes a 10-bit host I/O address and an 8-bit host data bus.
*/
`ifndef MIO_MAP_SVH
`define MIO_MAP_SVH

// Host I/O addresses
`define MIO_GAME_ADDR          10'h201
`define MIO_PRN_CTL_ADDR_PRI   10'h37a
`define MIO_PRN_CTL_ADDR_ALT   10'h3be
`define MIO_SERIAL_FIRST_BASE  10'h3f8
`define MIO_SERIAL_SECOND_BASE 10'h2f8
`define MIO_RTC_LOW_BASE       10'h340
`define MIO_RTC_ALT_BASE       10'h2c0

// Address bits ignored by the serial and clock chip decodes; clock chip index width
`define MIO_SERIAL_SPAN_BITS   3
`define MIO_RTC_SPAN_BITS      5
`define MIO_RTC_INDEX_BITS     4

// Printer control latch fields
`define MIO_CTL_STROBE_BIT     0
`define MIO_CTL_AUTO_LF_BIT    1
`define MIO_CTL_INIT_BIT       2
`define MIO_CTL_SELECT_IN_BIT  3
`define MIO_CTL_IRQ_EN_BIT     4

// Reset values
`define MIO_CTL_RESET          5'h00
`define MIO_DATA_RESET         8'h00

`endif

// file: mio_pkg.sv
/*
 Types shared by the multi-I/O port decode logic.
 Assumes nothing of its surroundings.
*/
package mio_pkg;
    typedef logic [7:0] mio_byte_t;
    typedef logic [4:0] mio_ctl_t;
    typedef enum logic [1:0] {
        mio_src_none,
        mio_src_printer,
        mio_src_game
    } mio_src_t;
endpackage

// file: mio_addr_match.sv
/*
 Fixed-range I/O address comparator for the multi-I/O decode.
 Assumes an address enable that is low during processor I/O cycles.
*/
`timescale 1ns/10ps
`default_nettype none

module mio_addr_match #(
    parameter int ADDR_W   = 10,
    parameter int BASE     = 0,
    parameter int LOW_BITS = 0
) (
    // Address side
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              addr_enable_n,
    // Result
    output logic                   hit
);
    localparam logic [ADDR_W-1:0] BASE_V = ADDR_W'(BASE);
    localparam logic [ADDR_W-1:0] ONE_V  = ADDR_W'(1);
    localparam logic [ADDR_W-1:0] KEEP   = ~((ONE_V << LOW_BITS) - ONE_V);

    if (LOW_BITS < 0 || LOW_BITS >= ADDR_W || ADDR_W > 30 || BASE >= (1 << ADDR_W)) begin : g_bad
        $error("mio_addr_match: parameters out of range");
    end

    // Ignored low bits never take part in the compare
    assign hit = !addr_enable_n && ((addr & KEEP) == (BASE_V & KEEP));
endmodule

`default_nettype wire

// file: mio_port_decode.sv
/*
 Host-bus front end of a multi-I/O card: printer control latch, serial
 port decode and clock, game port trigger and status, clock chip decode.
 Assumes bus inputs synchronous to core_clk and a slow reference clock.
*/
//
// Function
// [R1] Control write latches bits 0..4, ignores rest
// [R2] Control read returns latched bits 0..3
// [R3] Interrupt request needs enable and active acknowledge
// [R4] Serial selects for 3F8-3FF and 2F8-2FF
// [R5] Serial decode needs A9,A7..A3 high; A8 picks
// [R6] Low three address bits pass as index
// [R7] Reference clock halved for serial controllers
// [R8] Any game port write fires all timers
// [R9] Game read returns timers on bits 0..3
// [R10] Bits 4..7 show live raw button states
// [R11] Game buffer enable only during game reads
// [R12] Clock chip range chosen by static input
// [R13] Clock chip decodes 32, upper half aliases
// [R14] Serial selects active low, only in range
// [R15] Decode only while address enable active
// [R16] Interrupt leaves as request plus gate_n
// [R17] Reset clears control latch and enable
// [R18] Control port at 37A or 3BE
`timescale 1ns/10ps
`default_nettype none
`include "mio_map.svh"

module mio_port_decode #(
    parameter int ADDR_W = 10
) (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    // Host I/O bus
    input  wire logic [ADDR_W-1:0] io_addr,
    input  wire logic              io_rd_n,
    input  wire logic              io_wr_n,
    input  wire logic              addr_enable_n,
    input  wire logic [7:0]        io_data_in,
    output logic      [7:0]        io_data_out,
    output logic                   io_data_oe,
    // Static configuration
    input  wire logic              printer_addr_sel,
    input  wire logic              rtc_alt_range,
    // Printer port
    input  wire logic              printer_ack_n,
    output logic                   printer_strobe,
    output logic                   auto_line_feed,
    output logic                   printer_init,
    output logic                   printer_select_in,
    output logic                   printer_irq_request,
    output logic                   printer_irq_gate_n,
    // Serial ports
    input  wire logic              serial_ref_clk,
    output logic                   serial_first_select_n,
    output logic                   serial_second_select_n,
    output logic      [2:0]        serial_reg_index,
    output logic                   serial_master_clock_out,
    // Game port
    input  wire logic [3:0]        game_timer_in,
    input  wire logic [3:0]        game_button_open,
    output logic                   game_timer_fire,
    output logic                   game_buffer_enable_n,
    // Clock chip
    output logic                   clock_chip_select_low_range_n,
    output logic                   clock_chip_select_alt_range_n,
    output logic      [3:0]        rtc_reg_index
);
    if (ADDR_W != 10) begin : g_bad_width
        $error("mio_port_decode: host address must be 10 bits");
    end

    logic hit_ctl_pri;
    logic hit_ctl_alt;
    logic hit_ser_first;
    logic hit_ser_second;
    logic hit_game;
    logic hit_rtc_low;
    logic hit_rtc_alt;

    // Address decoders, all qualified by address enable (see [R15])
    mio_addr_match #(.ADDR_W(ADDR_W), .BASE(`MIO_PRN_CTL_ADDR_PRI), .LOW_BITS(0)) u_ctl_pri (
        .addr(io_addr), .addr_enable_n(addr_enable_n), .hit(hit_ctl_pri));
    mio_addr_match #(.ADDR_W(ADDR_W), .BASE(`MIO_PRN_CTL_ADDR_ALT), .LOW_BITS(0)) u_ctl_alt (
        .addr(io_addr), .addr_enable_n(addr_enable_n), .hit(hit_ctl_alt));
    // See [R4], see [R5], see [R6]
    mio_addr_match #(.ADDR_W(ADDR_W), .BASE(`MIO_SERIAL_FIRST_BASE),
                     .LOW_BITS(`MIO_SERIAL_SPAN_BITS)) u_ser_first (
        .addr(io_addr), .addr_enable_n(addr_enable_n), .hit(hit_ser_first));
    mio_addr_match #(.ADDR_W(ADDR_W), .BASE(`MIO_SERIAL_SECOND_BASE),
                     .LOW_BITS(`MIO_SERIAL_SPAN_BITS)) u_ser_second (
        .addr(io_addr), .addr_enable_n(addr_enable_n), .hit(hit_ser_second));
    mio_addr_match #(.ADDR_W(ADDR_W), .BASE(`MIO_GAME_ADDR), .LOW_BITS(0)) u_game (
        .addr(io_addr), .addr_enable_n(addr_enable_n), .hit(hit_game));
    // 32-address windows, see [R13]
    mio_addr_match #(.ADDR_W(ADDR_W), .BASE(`MIO_RTC_LOW_BASE),
                     .LOW_BITS(`MIO_RTC_SPAN_BITS)) u_rtc_low (
        .addr(io_addr), .addr_enable_n(addr_enable_n), .hit(hit_rtc_low));
    mio_addr_match #(.ADDR_W(ADDR_W), .BASE(`MIO_RTC_ALT_BASE),
                     .LOW_BITS(`MIO_RTC_SPAN_BITS)) u_rtc_alt (
        .addr(io_addr), .addr_enable_n(addr_enable_n), .hit(hit_rtc_alt));

    logic              rd;
    logic              wr;
    logic              hit_ctl;
    logic              game_wr;
    logic              game_rd;
    mio_pkg::mio_byte_t game_status;
    logic [3:0]        wdata_low;
    logic [2:0]        addr_low3;
    logic [3:0]        addr_low4;

    assign rd          = !io_rd_n;
    assign wr          = !io_wr_n;
    assign hit_ctl     = printer_addr_sel ? hit_ctl_pri : hit_ctl_alt; // see [R18]
    assign game_wr     = wr && hit_game;
    assign game_rd     = rd && hit_game;
    assign game_status = {game_button_open, game_timer_in}; // see [R9], see [R10]
    assign wdata_low   = io_data_in[3:0];
    assign addr_low3   = io_addr[2:0];
    assign addr_low4   = io_addr[`MIO_RTC_INDEX_BITS-1:0];

    // Printer control latch
    mio_pkg::mio_ctl_t ctl;
    mio_pkg::mio_ctl_t next_ctl;
    logic              printer_irq_enable;
    logic              next_irq_request;
    logic              next_irq_gate_n;

    assign printer_irq_enable = ctl[`MIO_CTL_IRQ_EN_BIT];

    always_comb begin
        next_ctl = ctl;
        if (wr && hit_ctl) begin
            next_ctl = io_data_in[4:0]; // see [R1]
        end
        next_irq_request = printer_irq_enable && !printer_ack_n; // see [R3]
        next_irq_gate_n  = !printer_irq_enable; // see [R16]
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctl                 <= `MIO_CTL_RESET; // see [R17]
            printer_irq_request <= 1'b0;
            printer_irq_gate_n  <= 1'b1;
        end else begin
            ctl                 <= next_ctl;
            printer_irq_request <= next_irq_request;
            printer_irq_gate_n  <= next_irq_gate_n;
        end
    end

    assign printer_strobe    = ctl[`MIO_CTL_STROBE_BIT];
    assign auto_line_feed    = ctl[`MIO_CTL_AUTO_LF_BIT];
    assign printer_init      = ctl[`MIO_CTL_INIT_BIT];
    assign printer_select_in = ctl[`MIO_CTL_SELECT_IN_BIT];

    // Bus answers and chip selects
    mio_pkg::mio_src_t  src;
    mio_pkg::mio_byte_t next_data_out;
    logic               next_data_oe;
    logic               game_wr_prev;
    logic               next_fire;
    logic               next_buf_n;
    logic               next_ser_first_n;
    logic               next_ser_second_n;
    logic               next_rtc_low_n;
    logic               next_rtc_alt_n;

    always_comb begin
        src = mio_pkg::mio_src_none;
        if (rd && hit_ctl) begin
            src = mio_pkg::mio_src_printer;
        end else if (game_rd) begin
            src = mio_pkg::mio_src_game;
        end
        case (src)
            mio_pkg::mio_src_printer: next_data_out = {4'h0, ctl[3:0]}; // see [R2]
            mio_pkg::mio_src_game:    next_data_out = game_status; // see [R9]
            default:                  next_data_out = `MIO_DATA_RESET;
        endcase
        next_data_oe      = (src != mio_pkg::mio_src_none);
        next_fire         = game_wr && !game_wr_prev; // see [R8]
        next_buf_n        = !game_rd; // see [R11]
        next_ser_first_n  = !hit_ser_first; // see [R14]
        next_ser_second_n = !hit_ser_second; // see [R14]
        next_rtc_low_n    = !(hit_rtc_low && !rtc_alt_range); // see [R12]
        next_rtc_alt_n    = !(hit_rtc_alt && rtc_alt_range); // see [R12]
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            io_data_out                   <= `MIO_DATA_RESET;
            io_data_oe                    <= 1'b0;
            game_wr_prev                  <= 1'b0;
            game_timer_fire               <= 1'b0;
            game_buffer_enable_n          <= 1'b1;
            serial_first_select_n         <= 1'b1;
            serial_second_select_n        <= 1'b1;
            serial_reg_index              <= 3'h0;
            clock_chip_select_low_range_n <= 1'b1;
            clock_chip_select_alt_range_n <= 1'b1;
            rtc_reg_index                 <= 4'h0;
        end else begin
            io_data_out                   <= next_data_out;
            io_data_oe                    <= next_data_oe;
            game_wr_prev                  <= game_wr;
            game_timer_fire               <= next_fire;
            game_buffer_enable_n          <= next_buf_n;
            serial_first_select_n         <= next_ser_first_n;
            serial_second_select_n        <= next_ser_second_n;
            serial_reg_index              <= addr_low3; // see [R6]
            clock_chip_select_low_range_n <= next_rtc_low_n;
            clock_chip_select_alt_range_n <= next_rtc_alt_n;
            rtc_reg_index                 <= addr_low4; // see [R13]
        end
    end

    // Serial master clock: toggle on each reference rising edge
    logic ref_prev;
    logic next_master_clk;

    always_comb begin
        next_master_clk = serial_master_clock_out;
        if (serial_ref_clk && !ref_prev) begin
            next_master_clk = !serial_master_clock_out; // see [R7]
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ref_prev                <= serial_ref_clk; // No false edge at release
            serial_master_clock_out <= 1'b0;
        end else begin
            ref_prev                <= serial_ref_clk;
            serial_master_clock_out <= next_master_clk;
        end
    end

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence game_write_start;
        !game_wr ##1 game_wr;
    endsequence

    sequence fire_pulse;
        game_timer_fire ##1 !game_timer_fire;
    endsequence

    a_ctl_latch_write: assert property ((wr && hit_ctl) |=> // see [R1]
        {printer_select_in, printer_init, auto_line_feed, printer_strobe} == $past(wdata_low))
        else $error("control latch did not take written bits");
    a_ctl_readback: assert property ((rd && hit_ctl) |=> io_data_oe && // see [R2]
        io_data_out == {4'h0, $past(printer_select_in), $past(printer_init),
                        $past(auto_line_feed), $past(printer_strobe)})
        else $error("control readback wrong");
    a_irq_raise: assert property ( // see [R3]
        (printer_irq_enable && !printer_ack_n) |=> printer_irq_request)
        else $error("printer interrupt not raised");
    a_irq_quiet: assert property ( // see [R3]
        (!printer_irq_enable || printer_ack_n) |=> !printer_irq_request)
        else $error("printer interrupt raised without cause");
    a_irq_gate: assert property ($rose(printer_irq_enable) |=> !printer_irq_gate_n) // see [R16]
        else $error("interrupt gate not opened");
    a_serial_first: assert property ((!addr_enable_n && io_addr[9:3] == 7'h7f) |=> // see [R5]
        !serial_first_select_n && serial_second_select_n)
        else $error("first serial select wrong");
    a_serial_second: assert property ((!addr_enable_n && io_addr[9:3] == 7'h5f) |=> // see [R4]
        serial_first_select_n && !serial_second_select_n)
        else $error("second serial select wrong");
    a_serial_index: assert property (1'b1 |=> serial_reg_index == $past(addr_low3)) // see [R6]
        else $error("serial register index not passed");
    a_master_toggle: assert property ( // see [R7]
        $rose(serial_ref_clk) |=> $changed(serial_master_clock_out))
        else $error("serial clock missed a toggle");
    a_master_hold: assert property ( // see [R7]
        !$rose(serial_ref_clk) |=> $stable(serial_master_clock_out))
        else $error("serial clock toggled spuriously");
    a_game_fire: assert property (game_write_start |=> fire_pulse) // see [R8]
        else $error("game timers not fired once");
    a_game_read: assert property (game_rd |=> io_data_oe && !game_buffer_enable_n && // see [R9]
        io_data_out == $past(game_status))
        else $error("game status read wrong");
    a_game_buffer: assert property (!game_rd |=> game_buffer_enable_n) // see [R11]
        else $error("game buffer enabled outside a read");
    a_rtc_alias: assert property ( // see [R13]
        (!addr_enable_n && io_addr[9:5] == 5'h1a && !rtc_alt_range) |=>
        !clock_chip_select_low_range_n && clock_chip_select_alt_range_n &&
        rtc_reg_index == $past(addr_low4))
        else $error("clock chip low range decode wrong");
    a_rtc_alt: assert property ( // see [R12]
        (!addr_enable_n && io_addr[9:5] == 5'h16 && rtc_alt_range) |=>
        clock_chip_select_low_range_n && !clock_chip_select_alt_range_n)
        else $error("clock chip alternate range decode wrong");
    a_dma_ignored: assert property (addr_enable_n |=> serial_first_select_n && // see [R15]
        serial_second_select_n && !io_data_oe && !game_timer_fire && game_buffer_enable_n)
        else $error("decode active during DMA cycle");
endmodule

`default_nettype wire

// file: mio_host_model.sv
/*
 Host processor model on the 8-bit I/O bus of the multi-I/O decode.
 Assumes core_clk and answers registered on the rising edge before the falling edge that samples them.
*/
`timescale 1ns/10ps
`default_nettype none

module mio_host_model (
    // Clock
    input  wire logic       core_clk,
    // Host bus
    output logic      [9:0] io_addr,
    output logic            io_rd_n,
    output logic            io_wr_n,
    output logic            addr_enable_n,
    output logic      [7:0] io_data_in,
    input  wire logic [7:0] io_data_out
);
    initial begin
        io_addr       = 10'h000;
        io_rd_n       = 1'b1;
        io_wr_n       = 1'b1;
        addr_enable_n = 1'b1;
        io_data_in    = 8'h00;
    end

    // Released lines show inverted values, never a stale copy
    task automatic idle();
        io_rd_n       = 1'b1;
        io_wr_n       = 1'b1;
        addr_enable_n = 1'b1;
        io_addr       = ~io_addr;
        io_data_in    = ~io_data_in;
    endtask

    task automatic drive_addr(input logic [9:0] a, input logic aen_n);
        @(negedge core_clk);
        io_addr       = a;
        addr_enable_n = aen_n;
        @(negedge core_clk);
    endtask

    task automatic bus_write(input logic [9:0] a, input logic [7:0] d);
        @(negedge core_clk);
        io_addr       = a;
        io_data_in    = d;
        addr_enable_n = 1'b0;
        io_wr_n       = 1'b0;
        @(negedge core_clk);
        idle();
    endtask

    task automatic bus_read(input logic [9:0] a, output logic [7:0] d);
        @(negedge core_clk);
        io_addr       = a;
        addr_enable_n = 1'b0;
        io_rd_n       = 1'b0;
        @(negedge core_clk);
        d = io_data_out;
        idle();
    endtask
endmodule

`default_nettype wire

// file: mio_port_decode_bench.sv
/*
 Self-checking bench of the multi-I/O port decode logic.
 Assumes the host model above and inputs driven on falling edges.
*/
`timescale 1ns/10ps
`default_nettype none
`include "mio_map.svh"

module mio_port_decode_bench;
    logic       core_clk = 1'b0;
    logic       rst_n, io_rd_n, io_wr_n, addr_enable_n, io_data_oe;
    logic [9:0] io_addr;
    logic [7:0] io_data_in, io_data_out, rd, d;
    logic       printer_addr_sel, rtc_alt_range, printer_ack_n;
    logic       printer_strobe, auto_line_feed, printer_init, printer_select_in;
    logic       printer_irq_request, printer_irq_gate_n, serial_ref_clk;
    logic       serial_first_select_n, serial_second_select_n;
    logic       serial_master_clock_out, game_timer_fire, game_buffer_enable_n;
    logic [2:0] serial_reg_index;
    logic [3:0] game_timer_in, game_button_open, rtc_reg_index, e;
    logic       clock_chip_select_low_range_n, clock_chip_select_alt_range_n;
    logic       ref_q, out_q;
    int         num_errors, compares, acc, ref_rises, out_toggles;
    logic [7:0] pats [4] = '{8'hff, 8'he5, 8'h1a, 8'h00};

    always #20 core_clk = ~core_clk;

    mio_host_model host (.core_clk, .io_addr, .io_rd_n, .io_wr_n,
        .addr_enable_n, .io_data_in, .io_data_out);

    mio_port_decode #(.ADDR_W(10)) dut (.core_clk, .rst_n, .io_addr, .io_rd_n,
        .io_wr_n, .addr_enable_n, .io_data_in, .io_data_out, .io_data_oe,
        .printer_addr_sel, .rtc_alt_range, .printer_ack_n, .printer_strobe,
        .auto_line_feed, .printer_init, .printer_select_in, .printer_irq_request,
        .printer_irq_gate_n, .serial_ref_clk, .serial_first_select_n,
        .serial_second_select_n, .serial_reg_index, .serial_master_clock_out,
        .game_timer_in, .game_button_open, .game_timer_fire, .game_buffer_enable_n,
        .clock_chip_select_low_range_n, .clock_chip_select_alt_range_n,
        .rtc_reg_index);

    // 3.6864 MHz reference from a fractional accumulator
    always @(negedge core_clk) begin
        acc = acc + 2949;
        if (acc >= 10000) begin
            acc = acc - 10000;
            serial_ref_clk = ~serial_ref_clk;
        end
    end

    always @(posedge core_clk) begin
        if (serial_ref_clk && !ref_q)
            ref_rises++;
        if (serial_master_clock_out !== out_q)
            out_toggles++;
        ref_q <= serial_ref_clk;
        out_q <= serial_master_clock_out;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        #2000000;
        num_errors++;
        stop_test();
    end

    initial begin
        {num_errors, compares, acc, ref_rises, out_toggles} = '0;
        {ref_q, out_q, serial_ref_clk} = 3'b000;
        rst_n            = 1'b0;
        printer_addr_sel = 1'b1;
        rtc_alt_range    = 1'b0;
        printer_ack_n    = 1'b1;
        game_timer_in    = 4'h5;
        game_button_open = 4'ha;
        repeat (2) @(negedge core_clk);
        rst_n = 1'b1;
        @(negedge core_clk);
        check({printer_strobe, auto_line_feed, printer_init, printer_select_in,
            printer_irq_gate_n, printer_irq_request, serial_first_select_n,
            serial_second_select_n}, 8'h0b);
        // Control latch write, gate and readback
        foreach (pats[i]) begin
            host.bus_write(`MIO_PRN_CTL_ADDR_PRI, pats[i]);
            @(negedge core_clk);
            check({4'h0, printer_select_in, printer_init, auto_line_feed,
                printer_strobe}, {4'h0, pats[i][3:0]});
            check({7'h0, printer_irq_gate_n}, {7'h0, ~pats[i][4]});
            host.bus_read(`MIO_PRN_CTL_ADDR_PRI, rd);
            check(rd, {4'h0, pats[i][3:0]});
        end
        // Interrupt needs enable and acknowledge
        host.bus_write(`MIO_PRN_CTL_ADDR_PRI, 8'h10);
        repeat (2) @(negedge core_clk);
        check({7'h0, printer_irq_request}, 8'h00);
        printer_ack_n = 1'b0;
        repeat (2) @(negedge core_clk);
        check({7'h0, printer_irq_request}, 8'h01);
        host.bus_write(`MIO_PRN_CTL_ADDR_PRI, 8'h0f);
        repeat (2) @(negedge core_clk);
        check({7'h0, printer_irq_request}, 8'h00);
        printer_ack_n = 1'b1;
        // Alternate control address
        printer_addr_sel = 1'b0;
        host.bus_write(`MIO_PRN_CTL_ADDR_PRI, 8'h00);
        host.bus_read(`MIO_PRN_CTL_ADDR_ALT, rd);
        check(rd, 8'h0f);
        host.bus_write(`MIO_PRN_CTL_ADDR_ALT, 8'h05);
        host.bus_read(`MIO_PRN_CTL_ADDR_ALT, rd);
        check(rd, 8'h05);
        printer_addr_sel = 1'b1;
        // Full address sweep, both clock chip ranges, then enable off
        for (int k = 0; k < 3; k++) begin
            rtc_alt_range = (k == 1);
            for (int a = 0; a < 1024; a++) begin
                host.drive_addr(a[9:0], k == 2);
                e[3] = !(k != 2 && a[9:3] == 7'h7f);
                e[2] = !(k != 2 && a[9:3] == 7'h5f);
                e[1] = !(k == 0 && a[9:5] == 5'h1a);
                e[0] = !(k == 1 && a[9:5] == 5'h16);
                check({4'h0, serial_first_select_n, serial_second_select_n,
                    clock_chip_select_low_range_n, clock_chip_select_alt_range_n},
                    {4'h0, e});
                check({1'b0, serial_reg_index, rtc_reg_index},
                    {1'b0, a[2:0], a[3:0]});
            end
        end
        // Game port trigger and status
        host.bus_write(`MIO_GAME_ADDR, 8'h00);
        check({7'h0, game_timer_fire}, 8'h01);
        @(negedge core_clk);
        check({7'h0, game_timer_fire}, 8'h00);
        for (int k = 0; k < 2; k++) begin
            d = k ? 8'h3c : 8'ha5;
            {game_button_open, game_timer_in} = d;
            host.bus_read(`MIO_GAME_ADDR, rd);
            check({6'h0, io_data_oe, game_buffer_enable_n}, 8'h02);
            check(rd, d);
        end
        host.bus_read(`MIO_PRN_CTL_ADDR_PRI, rd);
        check({7'h0, game_buffer_enable_n}, 8'h01);
        // Serial master clock follows every reference rise
        {ref_rises, out_toggles} = '0;
        repeat (3000) @(negedge core_clk);
        check({7'h0, (ref_rises - out_toggles) inside {[-2:2]}}, 8'h01);
        check({7'h0, ref_rises > 400}, 8'h01);
        stop_test();
    end
endmodule

`default_nettype wire
